// ### verilog/audio_out_defs.svh
// Offsets, field positions, reset values and timing counts of the audio output.
// Included by the design, the monitor and the bench; definitions only.
`ifndef AUDIO_OUT_DEFS_SVH
`define AUDIO_OUT_DEFS_SVH
`define CTRL_OFFSET        12'h000
`define STATUS_OFFSET      12'h004
`define BYPASS_OFFSET      12'h008
`define HEADER_OFFSET      12'h00C
`define CTRL_RESET         32'h0000_0020
`define HDR_RESET          20'h8_0400
`define CTL_RESET_BIT      0
`define CTL_MUTE_BIT       1
`define CTL_FMT_LSB        4
`define CTL_SRC_BIT        8
`define CTL_BYPASS_BIT     18
`define CTL_ES_BIT         19
`define CTL_SWAP_BIT       20
`define ST_UNDERFLOW_BIT   24
`define ST_HDR_LSB         4
`define ST_RATE_CHG_BIT    0
`define BLOCK_BYTES        128
`define START_BLOCKS       4
`define BYPASS_DEPTH       256
`define MUTE_FRAME_SAMPLES 1152
`define MCLK_DIV_BASE      8
`endif

// ### verilog/audio_out_pkg.sv
// Types shared by the audio output design.
// Needs no include file; nothing from audio_out_defs.svh is used here.
package audio_out_pkg;
    typedef enum logic [1:0] {
        out_idle,
        out_fill,
        out_play
    } out_state_t;
endpackage

// ### verilog/audio_pcm_out.sv
// Serial PCM and consumer digital audio output stage with its APB registers.
// Assumes a 25 MHz pclk; the external master clock is asynchronous and is
// sampled, so it must stay well below half the pclk rate.
`include "audio_out_defs.svh"

module audio_pcm_out
    import audio_out_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_master_clock,
    input  wire logic        header_valid,
    input  wire logic [19:0] header_in,
    input  wire logic        dec_sample_valid,
    input  wire logic [17:0] dec_sample,
    output logic             dec_sample_ready,
    output logic             pcm_bit_clock,
    output logic             pcm_lr_clock,
    output logic             pcm_serial_out,
    output logic             pcm_master_clock,
    output logic [2:0]       sample_rate_code,
    output logic             spdif_out,
    output logic             fast_interrupt,
    output logic             front_end_bypass,
    output logic             decoder_reset
);
    logic [31:0] ctrl_reg;
    logic        underflow_reg;
    logic        rate_chg_reg;
    logic [19:0] hdr_reg;
    logic [7:0]  buf_mem [0:`BYPASS_DEPTH*4-1];
    logic [9:0]  wr_ptr_reg;
    logic [9:0]  rd_ptr_reg;
    logic [10:0] bytes_reg;
    logic [7:0]  hold_byte_reg;
    logic        byte_phase_reg;
    out_state_t  state_reg;
    wire [3:0] fmt      = ctrl_reg[`CTL_FMT_LSB +: 4];
    // Reserved format codes behave as code zero.
    wire       fmt_ok   = (fmt[3:2] == 2'b00);
    wire       fmt18    = fmt_ok & fmt[1];
    wire       oversamp = fmt_ok & fmt[0];
    wire       bypass   = ctrl_reg[`CTL_BYPASS_BIT];
    wire       ext_src  = ctrl_reg[`CTL_SRC_BIT];
    wire       soft_rst = ctrl_reg[`CTL_RESET_BIT];
    // APB slave: zero wait states, unmapped addresses answer an error.
    wire apb_wr = psel & penable & pwrite;
    wire apb_rd = psel & ~pwrite;
    wire hit    = (paddr == `CTRL_OFFSET) | (paddr == `STATUS_OFFSET) |
                  (paddr == `BYPASS_OFFSET) | (paddr == `HEADER_OFFSET);
    wire wr_ctrl  = apb_wr & (paddr == `CTRL_OFFSET) & clk_en;
    wire wr_byp   = apb_wr & (paddr == `BYPASS_OFFSET) & clk_en;
    wire wr_stat  = apb_wr & (paddr == `STATUS_OFFSET) & clk_en;
    // Rate code mirrors header ID and frequency bits.
    wire [2:0] rate_code = {hdr_reg[19], hdr_reg[11:10]};
    // Control register; bypass may be set freely but is cleared only by
    // the module reset bit, so leaving bypass always passes a reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg[21:0] <= pwdata[21:0];
            ctrl_reg[`CTL_BYPASS_BIT] <= pwdata[`CTL_BYPASS_BIT] |
                (bypass & ~pwdata[`CTL_RESET_BIT]);
        end
    end
    // Header capture from the decoder.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_reg <= `HDR_RESET;
        end else if (clk_en && header_valid && !soft_rst) begin
            hdr_reg <= header_in;
        end
    end

    // Rate change detection: a new header whose rate bits differ.
    wire rate_change = clk_en & header_valid & ~soft_rst &
                       ({header_in[19], header_in[11:10]} != rate_code);
    // Sticky rate-change flag; writing one clears it, a new event wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_chg_reg <= 1'b0;
        end else if (rate_change) begin
            rate_chg_reg <= 1'b1;
        end else if (wr_stat && pwdata[`ST_RATE_CHG_BIT]) begin
            rate_chg_reg <= 1'b0;
        end
    end
    // Fast interrupt pulses once per rate change.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_interrupt <= 1'b0;
        end else if (clk_en) begin
            fast_interrupt <= rate_change;
        end
    end
    // APB read data and answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (apb_rd && !penable) begin
                case (paddr)
                    `CTRL_OFFSET:   prdata <= ctrl_reg;
                    `STATUS_OFFSET: prdata <= {7'h00, underflow_reg,
                        hdr_reg, 3'h0, rate_chg_reg};
                    `HEADER_OFFSET: prdata <= {12'h000, bytes_reg[7:0],
                        5'h00, sample_rate_code, 4'h0};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Bypass buffer loading: bytes arrive MSB first unless swapped.
    // Pairs are stored MSB byte at even address so reads need no swap.
    wire [7:0] in_byte = pwdata[7:0];
    always_ff @(posedge pclk) begin
        if (wr_byp && bypass) begin
            buf_mem[{wr_ptr_reg[9:1], byte_phase_reg ^
                     ctrl_reg[`CTL_SWAP_BIT]}] <= in_byte;
        end
    end

    // Bit-clock generator: half period counts in pclk cycles per format.
    logic [7:0]  div_reg;
    logic        bclk_reg;
    logic [5:0]  bit_cnt_reg;
    logic [23:0] shift_reg;
    logic        chan_reg;
    logic        mclk_reg;
    logic [2:0]  mclk_div_reg;
    logic [1:0]  mclk_sync_reg;
    logic        mclk_prev_reg;
    logic [10:0] mute_cnt_reg;
    logic        valid_reg;
    // Half bit-clock period per rate in pclk cycles, rounded down; the
    // internal reference is pclk itself, so rates are approximate.
    logic [7:0] half_div;
    always_comb begin
        case (rate_code)
            3'b110:  half_div = fmt18 ? 8'h08 : 8'h0C;
            3'b100:  half_div = fmt18 ? 8'h05 : 8'h08;
            3'b101:  half_div = fmt18 ? 8'h05 : 8'h08;
            3'b010:  half_div = fmt18 ? 8'h10 : 8'h18;
            3'b001:  half_div = fmt18 ? 8'h0A : 8'h10;
            default: half_div = fmt18 ? 8'h0B : 8'h11;
        endcase
    end
    // External master clock passes two flops before use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_sync_reg <= 2'b00;
            mclk_prev_reg <= 1'b0;
        end else if (clk_en) begin
            mclk_sync_reg <= {mclk_sync_reg[0], ext_master_clock};
            mclk_prev_reg <= mclk_sync_reg[1];
        end
    end

    // External mode ticks on each sampled master edge, 8 per half bit
    // clock when oversampled, one otherwise.
    wire ext_edge = mclk_sync_reg[1] ^ mclk_prev_reg;
    wire tick     = ext_src ? ext_edge : 1'b1;
    wire [7:0] lim = ext_src ? (oversamp ? 8'h07 : 8'h00)
                             : (half_div - 8'h01);
    wire half_done = tick & (div_reg == lim);
    wire fall      = half_done & bclk_reg;
    wire [5:0] last_bit = fmt18 ? 6'd23 : 6'd15;
    // Bit clock and channel counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg     <= 8'h00;
            bclk_reg    <= 1'b0;
            bit_cnt_reg <= 6'd0;
            chan_reg    <= 1'b0;
        end else if (clk_en) begin
            if (half_done) begin
                div_reg  <= 8'h00;
                bclk_reg <= ~bclk_reg;
                if (fall) begin
                    if (bit_cnt_reg >= last_bit) begin
                        bit_cnt_reg <= 6'd0;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 6'd1;
                    end
                    // The channel clock turns one bit before the next MSB.
                    if (bit_cnt_reg == last_bit - 6'd1) begin
                        chan_reg <= ~chan_reg;
                    end
                end
            end else if (tick) begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end

    // Master clock: internal mode toggles on every pclk cycle
    // when oversampling, otherwise follows the bit clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_reg     <= 1'b0;
            mclk_div_reg <= 3'd0;
        end else if (clk_en) begin
            if (ext_src) begin
                mclk_reg <= mclk_sync_reg[1];
            end else if (!oversamp) begin
                mclk_reg <= bclk_reg;
            end else begin
                mclk_div_reg <= mclk_div_reg + 3'd1;
                mclk_reg     <= mclk_div_reg[0];
            end
        end
    end
    // Bypass state: play starts after four blocks, just before a left word,
    // so the host's left/right pairing holds.
    wire [10:0] start_level = 11'(`BLOCK_BYTES * `START_BLOCKS);
    wire        word_start  = fall & (bit_cnt_reg >= last_bit);
    wire        have_pair   = (bytes_reg >= 11'd2);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= out_idle;
        end else if (clk_en) begin
            case (state_reg)
                out_idle: if (bypass) state_reg <= out_fill;
                out_fill: if (bytes_reg >= start_level && word_start &&
                              chan_reg)
                              state_reg <= out_play;
                out_play: if (!bypass) state_reg <= out_idle;
                default:  state_reg <= out_idle;
            endcase
        end
    end

    // Whole blocks only count toward playable bytes.
    wire block_done = wr_byp & bypass & (wr_ptr_reg[6:0] == 7'h7F);
    wire take_pair  = word_start & (state_reg == out_play) & have_pair;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg     <= 10'd0;
            rd_ptr_reg     <= 10'd0;
            bytes_reg      <= 11'd0;
            byte_phase_reg <= 1'b0;
        end else if (clk_en) begin
            if (soft_rst) begin
                wr_ptr_reg     <= 10'd0;
                rd_ptr_reg     <= 10'd0;
                bytes_reg      <= 11'd0;
                byte_phase_reg <= 1'b0;
            end else begin
                if (wr_byp && bypass) begin
                    wr_ptr_reg     <= wr_ptr_reg + 10'd1;
                    byte_phase_reg <= ~byte_phase_reg;
                end
                if (take_pair) begin
                    rd_ptr_reg <= rd_ptr_reg + 10'd2;
                end
                bytes_reg <= bytes_reg
                    + (block_done ? 11'd128 : 11'd0)
                    - (take_pair ? 11'd2 : 11'd0);
            end
        end
    end
    // Underflow: a word is due but no sample is ready.
    wire starve = word_start & ((state_reg == out_play) ? ~have_pair
                  : (~bypass & ~dec_sample_valid & ~soft_rst));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            underflow_reg <= 1'b0;
        end else if (clk_en) begin
            if (starve) begin
                underflow_reg <= 1'b1;
            end else if (wr_stat && pwdata[`ST_UNDERFLOW_BIT]) begin
                underflow_reg <= 1'b0;
            end
        end
    end

    // Mute for one frame after a rate change; validity drops with it and returns one cycle after it ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute_cnt_reg <= 11'd0;
            valid_reg    <= 1'b1;
        end else if (clk_en) begin
            if (rate_change) begin
                valid_reg    <= 1'b0;
                mute_cnt_reg <= 11'(`MUTE_FRAME_SAMPLES);
            end else if (word_start && chan_reg && mute_cnt_reg != 11'd0) begin
                mute_cnt_reg <= mute_cnt_reg - 11'd1;
            end else if (mute_cnt_reg == 11'd0) begin
                valid_reg <= 1'b1;
            end
        end
    end

    // Word assembly: bypass pads 1 below and 7 above in 18-bit.
    wire [15:0] byp_word = {buf_mem[rd_ptr_reg], buf_mem[rd_ptr_reg + 10'd1]};
    wire [17:0] sample18 = (state_reg == out_play) ? {byp_word, 1'b0, 1'b0}
                         : dec_sample;
    wire        silent   = ctrl_reg[`CTL_MUTE_BIT] | (mute_cnt_reg != 11'd0) |
                           soft_rst | starve;
    wire [23:0] word16   = {sample18[17:2], 8'h00};
    wire [23:0] word18   = {6'h00, (state_reg == out_play) ?
                            {byp_word, 1'b0, 1'b0} >> 1 : sample18};
    // Shift register loads at the word boundary, one bit after the channel
    // clock turns, and shifts on each falling bit clock edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= 24'h00_0000;
        end else if (clk_en && fall) begin
            if (word_start) begin
                shift_reg <= silent ? 24'h00_0000 : (fmt18 ? word18 : word16);
            end else begin
                shift_reg <= {shift_reg[22:0], 1'b0};
            end
        end
    end

    // Biphase-mark encoder for the digital output, one cell per bit
    // clock half, held in external mode without oversampling; validity and preamble framing kept minimal.
    logic spdif_reg;
    wire  spdif_ok = ~ext_src | oversamp;
    wire  sp_bit   = (bit_cnt_reg == 6'd0) ? ~valid_reg : shift_reg[23];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spdif_reg <= 1'b0;
        end else if (clk_en && half_done && spdif_ok) begin
            spdif_reg <= bclk_reg ? ~spdif_reg : (spdif_reg ^ sp_bit);
        end
    end

    // Registered pin outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcm_bit_clock    <= 1'b0;
            pcm_lr_clock     <= 1'b0;
            pcm_serial_out   <= 1'b0;
            pcm_master_clock <= 1'b0;
            sample_rate_code <= 3'b101;
            spdif_out        <= 1'b0;
            dec_sample_ready <= 1'b0;
            front_end_bypass <= 1'b0;
            decoder_reset    <= 1'b0;
        end else if (clk_en) begin
            pcm_bit_clock    <= bclk_reg;
            pcm_lr_clock     <= chan_reg;
            pcm_serial_out   <= shift_reg[23];
            pcm_master_clock <= mclk_reg;
            sample_rate_code <= rate_code;
            spdif_out        <= spdif_reg;
            dec_sample_ready <= word_start & ~bypass;
            front_end_bypass <= ctrl_reg[`CTL_ES_BIT] | bypass;
            decoder_reset    <= soft_rst;
        end
    end
endmodule

// ### sim/audio_pcm_out_monitor.sv
// Concurrent checks on the audio output stage's bus, header and control ports.
// Bound to audio_pcm_out; sees only its ports and uses the shared offsets.
`include "audio_out_defs.svh"
module audio_pcm_out_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        header_valid,
    input wire logic [19:0] header_in,
    input wire logic [2:0]  sample_rate_code,
    input wire logic        fast_interrupt,
    input wire logic        front_end_bypass,
    input wire logic        decoder_reset
);
    logic        setup;
    logic        ctrl_wr;
    logic [19:0] hdr_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A request is taken in setup; a control write lands in its access cycle.
    assign setup   = psel && !penable && clk_en;
    assign ctrl_wr = psel && penable && pready && pwrite &&
                     paddr == `CTRL_OFFSET;
    // Last header taken, so the rate code can be traced back to its cause.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hdr_q <= `HDR_RESET;
        else if (header_valid) hdr_q <= header_in;
    end
    ready_after_setup_a: assert property (setup |=> pready)
        else $error("no ready one cycle after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    unmapped_refused_a: assert property (
        setup && paddr > `HEADER_OFFSET |=> pslverr)
        else $error("unmapped access not refused");
    rate_from_header_a: assert property (header_valid |->
        ##[1:4] sample_rate_code == {hdr_q[19], hdr_q[11:10]})
        else $error("rate code does not follow header");
    irq_on_change_a: assert property (header_valid &&
        {header_in[19], header_in[11:10]} != sample_rate_code
        |-> ##[1:4] fast_interrupt)
        else $error("no interrupt on rate change");
    irq_single_a: assert property (fast_interrupt |=> !fast_interrupt)
        else $error("interrupt longer than one cycle");
    reset_rate_a: assert property (
        $rose(presetn) |-> sample_rate_code == 3'h5)
        else $error("rate code not 48k after reset");
    bypass_set_a: assert property (ctrl_wr &&
        (pwdata[18] || pwdata[19]) |-> ##2 front_end_bypass)
        else $error("front end bypass not set");
    bypass_leave_a: assert property (ctrl_wr && pwdata[0] &&
        !pwdata[18] && !pwdata[19] |-> ##2 !front_end_bypass)
        else $error("bypass not left with reset");
    reset_bit_a: assert property (
        ctrl_wr |-> ##2 decoder_reset == $past(pwdata[0], 2))
        else $error("decoder reset differs from control");
    rate_change_c: cover property (fast_interrupt);
    refused_c: cover property (pslverr);
    bypass_c: cover property ($rose(front_end_bypass));
endmodule

// ### sim/audio_far_side.sv
// Far side of the audio output: external PLL clock, serial DAC word capture
// and clock ratio measurement. Assumes data is stable at rising bit edges.
module audio_far_side (
    input  wire logic        pcm_bit_clock,
    input  wire logic        pcm_lr_clock,
    input  wire logic        pcm_serial_out,
    input  wire logic        pcm_master_clock,
    input  wire logic [2:0]  sample_rate_code,
    output logic             ext_master_clock,
    output logic [23:0]      left_word,
    output logic [23:0]      right_word,
    output logic [7:0]       half_bits,
    output logic [7:0]       mclk_per_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] shift_q = 24'h00_0000;
    int          bits = 0;
    int          since_lr = 0;
    int          mclks = 0;
    // Scaled PLL: slow enough for pclk to sample, period set by rate code.
    initial ext_master_clock = 1'b0;
    always begin
        #((sample_rate_code === 3'h5) ? 160 : 200);
        ext_master_clock = ~ext_master_clock;
    end
    // MSB first; the first rise after a channel change ends the old word.
    always @(posedge pcm_bit_clock) begin
        shift_q = {shift_q[22:0], pcm_serial_out};
        since_lr++;
        bits++;
        if (since_lr == 1 && pcm_lr_clock) left_word = shift_q;
        else if (since_lr == 1) right_word = shift_q;
        mclk_per_bit = mclks[7:0];
        mclks = 0;
    end
    // The delay keeps a coincident bit edge in the half that it ends.
    always @(pcm_lr_clock) begin
        #1;
        half_bits = bits[7:0];
        bits = 0;
        since_lr = 0;
    end
    // Counted late so a coincident master edge opens the new bit period.
    always @(posedge pcm_master_clock) begin
        #1;
        mclks++;
    end
endmodule

// ### sim/decoded_audio_pcm_spdif_output_bench.sv
// Self-checking bench for the audio output stage: header table, formats,
// clock source, underflow and bypass. Needs the design and far-side model.
`include "audio_out_defs.svh"
module decoded_audio_pcm_spdif_output_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [19:0] hdr; logic [2:0] code;} row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        header_valid = 1'b0;
    logic [19:0] header_in = 20'h0_0000;
    logic        dec_sample_valid = 1'b1;
    logic [17:0] dec_sample = 18'h2_A5C3;
    logic [31:0] prdata, rd;
    logic [2:0]  sample_rate_code;
    logic [23:0] left_word, right_word;
    logic [7:0]  half_bits, mclk_per_bit;
    logic        pready, pslverr, er, ext_master_clock, dec_sample_ready;
    logic        pcm_bit_clock, pcm_lr_clock, pcm_serial_out;
    logic        pcm_master_clock, fast_interrupt, front_end_bypass;
    logic        decoder_reset, spdif_out;
    int          n_fail = 0;
    int          n_compared = 0;
    int          n_edges = 0;
    int          n_ready = 0;
    int          n_base, n_rbase;
    logic [7:0]  pat [4] = '{8'hA5, 8'hC3, 8'h5A, 8'h3C};
    row_t        rows [6] = '{'{20'hC_9800, 3'h6}, '{20'hA_503C, 3'h4},
        '{20'h8_E6C1, 3'h5}, '{20'h7_1A55, 3'h2}, '{20'h2_3300, 3'h0},
        '{20'h4_F702, 3'h1}};
    always #20 pclk = ~pclk;
    // Activity counts for the ports that the far-side model does not watch.
    always @(posedge pclk) if (dec_sample_ready === 1'b1) n_ready++;
    always @(spdif_out) n_edges++;
    audio_pcm_out dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_master_clock, .header_valid, .header_in, .dec_sample_valid,
        .dec_sample, .dec_sample_ready, .pcm_bit_clock, .pcm_lr_clock,
        .pcm_serial_out, .pcm_master_clock, .sample_rate_code,
        .spdif_out, .fast_interrupt, .front_end_bypass, .decoder_reset);
    audio_far_side far (.pcm_bit_clock, .pcm_lr_clock, .pcm_serial_out,
        .pcm_master_clock, .sample_rate_code, .ext_master_clock,
        .left_word, .right_word, .half_bits, .mclk_per_bit);
    task automatic close_out();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One setup and one access cycle; request held until ready is seen.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
        if (n >= 16) begin
            n_fail++;
            close_out();
        end
    endtask
    // Waits for channel clock changes; a stalled clock ends the run.
    task automatic wait_lr(input int n);
        int k;
        int t;
        logic q;
        q = pcm_lr_clock;
        k = 0;
        t = 0;
        while (k < n && t < 40000) begin
            @(posedge pclk);
            t++;
            if (pcm_lr_clock !== q) begin
                k++;
                q = pcm_lr_clock;
            end
        end
        if (k < n) begin
            n_fail++;
            close_out();
        end
    endtask
    // Left MSB, LSB, then right MSB, LSB, one byte per write.
    task automatic load(input int blocks);
        for (int i = 0; i < blocks * 128; i++) begin
            apb(1'b1, `BYPASS_OFFSET, {24'h00_0000, pat[i % 4]});
        end
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(sample_rate_code, 3'h5);
        apb(1'b0, `CTRL_OFFSET, 32'h0000_0000);
        chk(rd, `CTRL_RESET);
        for (int i = 0; i < 6; i++) begin
            header_in <= rows[i].hdr;
            header_valid <= 1'b1;
            @(posedge pclk);
            header_valid <= 1'b0;
            repeat (6) @(posedge pclk);
            chk(sample_rate_code, rows[i].code);
            apb(1'b0, `STATUS_OFFSET, 32'h0000_0000);
            chk(rd[24:4], {1'b0, rows[i].hdr});
        end
        // A second reset clears the frame of mute left by the table.
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        n_base = n_edges;
        n_rbase = n_ready;
        wait_lr(4);
        chk(left_word, 24'h02_A5C3);
        chk(n_edges - n_base > 40, 1'b1);
        chk(n_ready - n_rbase > 2, 1'b1);
        chk(half_bits, 8'h18);
        chk(mclk_per_bit, 8'h01);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0000);
        wait_lr(4);
        chk(half_bits, 8'h10);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_00E0);
        wait_lr(4);
        chk(half_bits, 8'h10);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0130);
        wait_lr(4);
        chk(mclk_per_bit, 8'h08);
        chk(half_bits, 8'h18);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0020);
        dec_sample_valid <= 1'b0;
        wait_lr(4);
        apb(1'b0, `STATUS_OFFSET, 32'h0000_0000);
        chk(rd[24], 1'b1);
        dec_sample_valid <= 1'b1;
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(er, 1'b1);
        apb(1'b1, `CTRL_OFFSET, 32'h0004_0020);
        chk(front_end_bypass, 1'b1);
        n_rbase = n_ready;
        load(3);
        wait_lr(4);
        chk(left_word == 24'h01_4B86, 1'b0);
        load(1);
        wait_lr(6);
        chk(left_word, 24'h01_4B86);
        chk(right_word, 24'h00_B478);
        chk(n_ready - n_rbase, 0);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0020);
        chk(front_end_bypass, 1'b1);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0021);
        chk(front_end_bypass, 1'b0);
        chk(decoder_reset, 1'b1);
        apb(1'b1, `CTRL_OFFSET, 32'h0008_0020);
        chk(front_end_bypass, 1'b1);
        close_out();
    end
endmodule
bind audio_pcm_out audio_pcm_out_monitor mon (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .header_valid, .header_in, .sample_rate_code, .fast_interrupt,
    .front_end_bypass, .decoder_reset);
